// >>> hw/sideband_pkg.sv
// Constants shared by the sideband transceiver and its event flags
package sideband_pkg;

	// ****************************************************************
	// Register map (byte addresses)
	// ****************************************************************
	localparam logic [7:0] CTRL_OFFS = 8'h00;
	localparam logic [7:0] STATUS_OFFS = 8'h04;
	localparam logic [7:0] EVENT_OFFS = 8'h08;
	localparam logic [7:0] MASK_OFFS = 8'h0c;
	localparam logic [7:0] THRESH_OFFS = 8'h10;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int CTRL_FORCE_RESET_BIT = 0;
	localparam int CTRL_FORCE_LOWPOWER_BIT = 1;
	localparam int ST_MODULE_IRQ_BIT = 0;
	localparam int ST_PRESENT_BIT = 1;
	localparam int ST_RESET_BIT = 2;
	localparam int ST_LOWPOWER_BIT = 3;
	localparam int ST_STRAP_LSB = 4;
	localparam int EV_IRQ_BIT = 0;
	localparam int EV_PRESENT_BIT = 1;
	localparam int EV_REMOVED_BIT = 2;
	localparam int EVENT_COUNT = 3;

	// ****************************************************************
	// Reset values and line decoding
	// ****************************************************************
	localparam logic [1:0] CTRL_RESET = 2'h0;
	localparam logic [2:0] MASK_RESET = 3'h0;
	localparam int LINE_MV_WIDTH = 12;
	localparam int THRESHOLD_MV = 2496;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage

// >>> hw/event_flags.sv
// Sticky event flags with read-clear, mask and one level interrupt
`timescale 1ns/1ps
module event_flags #(
	parameter int N = 3
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// Events and software access
	input wire logic [N-1:0] set,
	input wire logic clear_all,
	input wire logic mask_we,
	input wire logic [N-1:0] mask_wdata,
	// State
	output logic [N-1:0] status,
	output logic [N-1:0] mask,
	output logic irq
);
	initial begin
		if (N < 1 || N > 32)
			$error("event_flags: N out of range");
	end

	// ****************************************************************
	// Flags: a new event beats a read-clear in the same cycle
	// ****************************************************************
	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_flag
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					status[i] <= 1'b0;
				end else if (ce) begin
					status[i] <= set[i] | (status[i] & ~clear_all);
				end
			end
		end
	endgenerate

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mask <= N'(sideband_pkg::MASK_RESET);
		end else if (ce && mask_we) begin
			mask <= mask_wdata;
		end
	end

	// Registered so the interrupt pin is glitch free
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq <= 1'b0;
		end else if (ce) begin
			irq <= |(status_nxt() & mask);
		end
	end

	function automatic logic [N-1:0] status_nxt();
		return set | (status & ~{N{clear_all}});
	endfunction

	set_wins_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(ce && clear_all && set != '0) |=> ((status & $past(set)) ==
		$past(set)))
		else $error("event lost on clear");
endmodule // event_flags

// >>> hw/sideband_host_xcvr.sv
// Host-side transceiver for the two shared sideband lines
//
// Chosen here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module sideband_host_xcvr #(
	parameter int THRESH_MV = sideband_pkg::THRESHOLD_MV
) (
	// Clock, reset, enable
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// Host side
	input wire logic host_reset_request_n,
	input wire logic host_lowpower_request_n,
	output logic host_irq_out_n,
	output logic host_present_out_n,
	// Polarity straps
	input wire logic irq_polarity_strap,
	input wire logic reset_polarity_strap,
	input wire logic present_polarity_strap,
	input wire logic lowpower_polarity_strap,
	// Shared lines: own drive pins and sampled line levels in mV
	output logic module_reset_drive_n,
	output logic lowpower_line_drive,
	input wire logic [11:0] shared_irq_reset_line,
	input wire logic [11:0] shared_lowpower_present_line,
	// AXI4-Lite write address and data
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// AXI4-Lite write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Interrupt
	output logic irq
);
	localparam int MVW = sideband_pkg::LINE_MV_WIDTH;
	localparam int NEV = sideband_pkg::EVENT_COUNT;
	localparam logic [MVW-1:0] THRESH = MVW'(THRESH_MV);

	initial begin
		if (THRESH_MV < 1 || THRESH_MV >= (1 << MVW))
			$error("sideband_host_xcvr: THRESH_MV out of range");
	end

	// ****************************************************************
	// Address decode
	// ****************************************************************
	function automatic logic is_reg(input logic [7:0] a,
		input logic [7:0] offs);
		return a == offs;
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		return is_reg(a, sideband_pkg::CTRL_OFFS) ||
			is_reg(a, sideband_pkg::STATUS_OFFS) ||
			is_reg(a, sideband_pkg::EVENT_OFFS) ||
			is_reg(a, sideband_pkg::MASK_OFFS) ||
			is_reg(a, sideband_pkg::THRESH_OFFS);
	endfunction

	// ****************************************************************
	// Line decode and polarity paths
	// ****************************************************************
	logic [3:0] strap_r;
	logic module_irq_r;
	logic present_r;
	logic reset_active_r;
	logic lowpower_active_r;
	logic [1:0] ctrl_r;
	logic line_irq_hi;
	logic line_prs_hi;
	logic reset_req;
	logic lowpower_req;

	// Levels at or below threshold mean the module pulls the line low
	assign line_irq_hi = shared_irq_reset_line > THRESH;
	assign line_prs_hi = shared_lowpower_present_line > THRESH;
	assign reset_req = ~host_reset_request_n ^ reset_polarity_strap;
	assign lowpower_req = ~host_lowpower_request_n ^
		lowpower_polarity_strap;

	// Straps are static; sampled only so STATUS can show them
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			strap_r <= 4'h0;
		end else if (ce) begin
			strap_r <= {lowpower_polarity_strap, present_polarity_strap,
				reset_polarity_strap, irq_polarity_strap};
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			module_irq_r <= 1'b0;
			present_r <= 1'b0;
			host_irq_out_n <= 1'b1;
			host_present_out_n <= 1'b1;
		end else if (ce) begin
			module_irq_r <= ~line_irq_hi;
			present_r <= ~line_prs_hi;
			host_irq_out_n <= line_irq_hi ^ irq_polarity_strap;
			host_present_out_n <= line_prs_hi ^
				present_polarity_strap;
		end
	end

	// Software can force either request on top of the host pins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			reset_active_r <= 1'b0;
			lowpower_active_r <= 1'b0;
			module_reset_drive_n <= 1'b1;
			lowpower_line_drive <= 1'b0;
		end else if (ce) begin
			reset_active_r <= reset_req |
				ctrl_r[sideband_pkg::CTRL_FORCE_RESET_BIT];
			module_reset_drive_n <= ~(reset_req |
				ctrl_r[sideband_pkg::CTRL_FORCE_RESET_BIT]);
			lowpower_active_r <= lowpower_req |
				ctrl_r[sideband_pkg::CTRL_FORCE_LOWPOWER_BIT];
			lowpower_line_drive <= lowpower_req |
				ctrl_r[sideband_pkg::CTRL_FORCE_LOWPOWER_BIT];
		end
	end

	// ****************************************************************
	// AXI4-Lite slave
	// ****************************************************************
	logic aw_got_r;
	logic w_got_r;
	logic [7:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic aw_hs;
	logic w_hs;
	logic ar_hs;
	logic do_write;
	logic aw_got_nxt;
	logic w_got_nxt;
	logic bvalid_nxt;
	logic rvalid_nxt;
	logic [NEV-1:0] ev_status;
	logic [NEV-1:0] ev_mask;
	logic [NEV-1:0] ev_set;
	logic ev_clear;
	logic mask_we;

	assign aw_hs = awvalid & awready;
	assign w_hs = wvalid & wready;
	assign ar_hs = arvalid & arready;
	assign do_write = aw_got_r & w_got_r & ~bvalid;

	always_comb begin
		aw_got_nxt = (aw_got_r | aw_hs) & ~do_write;
		w_got_nxt = (w_got_r | w_hs) & ~do_write;
		bvalid_nxt = (bvalid & ~bready) | do_write;
		rvalid_nxt = (rvalid & ~rready) | ar_hs;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= sideband_pkg::RESP_OKAY;
		end else if (ce) begin
			aw_got_r <= aw_got_nxt;
			w_got_r <= w_got_nxt;
			awready <= ~aw_got_nxt & ~bvalid_nxt;
			wready <= ~w_got_nxt & ~bvalid_nxt;
			bvalid <= bvalid_nxt;
			if (do_write) begin
				bresp <= mapped(awaddr_r) ? sideband_pkg::RESP_OKAY :
					sideband_pkg::RESP_DECERR;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awaddr_r <= 8'h00;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
		end else if (ce) begin
			if (aw_hs)
				awaddr_r <= awaddr;
			if (w_hs) begin
				wdata_r <= wdata;
				wstrb_r <= wstrb;
			end
		end
	end

	// Only byte lane 0 holds writable bits
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r <= sideband_pkg::CTRL_RESET;
		end else if (ce && do_write && wstrb_r[0] &&
			is_reg(awaddr_r, sideband_pkg::CTRL_OFFS)) begin
			ctrl_r <= wdata_r[1:0];
		end
	end

	assign mask_we = do_write & wstrb_r[0] &
		is_reg(awaddr_r, sideband_pkg::MASK_OFFS);
	assign ev_clear = ar_hs & is_reg(araddr, sideband_pkg::EVENT_OFFS);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= sideband_pkg::RESP_OKAY;
		end else if (ce) begin
			arready <= ~rvalid_nxt;
			rvalid <= rvalid_nxt;
			if (ar_hs) begin
				rresp <= mapped(araddr) ? sideband_pkg::RESP_OKAY :
					sideband_pkg::RESP_DECERR;
				unique case (araddr)
				sideband_pkg::CTRL_OFFS: rdata <= {30'h0, ctrl_r};
				sideband_pkg::STATUS_OFFS: rdata <= {24'h0, strap_r,
					lowpower_active_r, reset_active_r, present_r,
					module_irq_r};
				sideband_pkg::EVENT_OFFS: rdata <= {29'h0, ev_status};
				sideband_pkg::MASK_OFFS: rdata <= {29'h0, ev_mask};
				sideband_pkg::THRESH_OFFS: rdata <= {20'h0, THRESH};
				default: rdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ****************************************************************
	// Events and interrupt
	// ****************************************************************
	always_comb begin
		ev_set = '0;
		ev_set[sideband_pkg::EV_IRQ_BIT] = ~line_irq_hi & ~module_irq_r;
		ev_set[sideband_pkg::EV_PRESENT_BIT] = ~line_prs_hi & ~present_r;
		ev_set[sideband_pkg::EV_REMOVED_BIT] = line_prs_hi & present_r;
	end

	event_flags #(
		.N(NEV)
	) u_flags (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.set(ev_set),
		.clear_all(ev_clear),
		.mask_we(mask_we),
		.mask_wdata(wdata_r[NEV-1:0]),
		.status(ev_status),
		.mask(ev_mask),
		.irq(irq)
	);

	// ****************************************************************
	// Checks
	// ****************************************************************
	irq_path_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce |=> host_irq_out_n == ($past(shared_irq_reset_line) > THRESH
		^ $past(irq_polarity_strap)))
		else $error("host irq output wrong");
	irq_strap_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(ce && irq_polarity_strap) |=> (host_irq_out_n == module_irq_r))
		else $error("irq strap not inverting");
	reset_req_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(ce && !host_reset_request_n && !reset_polarity_strap) |=>
		!module_reset_drive_n && reset_active_r)
		else $error("reset request not driven");
	reset_drive_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce |=> module_reset_drive_n == !reset_active_r)
		else $error("reset pin disagrees with state");
	reset_strap_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(ce && host_reset_request_n && reset_polarity_strap) |=>
		!module_reset_drive_n)
		else $error("reset strap not inverting");
	lowpower_req_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(ce && !host_lowpower_request_n && !lowpower_polarity_strap) |=>
		lowpower_line_drive)
		else $error("low-power request not driven");
	lowpower_line_a: assert property (@(posedge aclk)
		disable iff (!aresetn) (ce && aresetn &&
		!ctrl_r[sideband_pkg::CTRL_FORCE_LOWPOWER_BIT]) |=>
		lowpower_line_drive == ($past(host_lowpower_request_n) ==
		$past(lowpower_polarity_strap)))
		else $error("low-power line wrong");
	present_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce |=> host_present_out_n == ($past(shared_lowpower_present_line)
		> THRESH ^ $past(present_polarity_strap)))
		else $error("present output wrong");
	threshold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(ce && shared_irq_reset_line == THRESH) |=> module_irq_r)
		else $error("threshold level not low");
	freeze_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!ce |=> $stable(host_irq_out_n) && $stable(module_reset_drive_n)
		&& $stable(rvalid) && $stable(bvalid))
		else $error("state moved with ce low");
	duplex_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(ce && reset_req && shared_irq_reset_line <= THRESH) |=>
		!module_reset_drive_n && module_irq_r)
		else $error("directions not independent");
endmodule // sideband_host_xcvr

// >>> dv/module_side_model.sv
// Behavioural model of the pluggable module's sideband controller
`timescale 1ns/1ps
module module_side_model (
	// Host drive pins seen by the module
	input wire logic module_reset_drive_n,
	input wire logic lowpower_line_drive,
	// Module intent from the bench
	input wire logic irq_assert,
	input wire logic present,
	input wire logic at_edge,
	// Sampled line levels in mV, and the host requests as the module sees them
	output logic [11:0] shared_irq_reset_line,
	output logic [11:0] shared_lowpower_present_line,
	output logic in_reset,
	output logic in_lowpower
);
	logic [11:0] lo_mv;
	logic [11:0] hi_mv;
	// Edge mode sits right on the threshold to catch an off-by-one
	assign lo_mv = at_edge ? 12'h9c0 : 12'h3e8;
	assign hi_mv = at_edge ? 12'h9c1 : 12'hce4;
	// Module levels do not depend on the host drive
	assign shared_irq_reset_line = irq_assert ? lo_mv : hi_mv;
	assign shared_lowpower_present_line = present ? lo_mv : hi_mv;
	assign in_reset = !module_reset_drive_n;
	assign in_lowpower = lowpower_line_drive;
endmodule // module_side_model

// >>> dv/tb_module_sideband_host_transceiver.sv
// Self-checking bench for the sideband host transceiver
`timescale 1ns/1ps
module tb_module_sideband_host_transceiver;
	logic aclk, aresetn, ce, host_reset_request_n, host_lowpower_request_n;
	logic host_irq_out_n, host_present_out_n, module_reset_drive_n;
	logic irq_polarity_strap, reset_polarity_strap, present_polarity_strap;
	logic lowpower_polarity_strap, lowpower_line_drive, irq;
	logic [11:0] shared_irq_reset_line, shared_lowpower_present_line;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, r;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, irq_assert, present, at_edge;
	int n_fail, checks_done, cyc;

	sideband_host_xcvr dut (.aclk, .aresetn, .ce, .host_reset_request_n,
		.host_lowpower_request_n, .host_irq_out_n, .host_present_out_n,
		.irq_polarity_strap, .reset_polarity_strap, .present_polarity_strap,
		.lowpower_polarity_strap, .module_reset_drive_n, .lowpower_line_drive,
		.shared_irq_reset_line, .shared_lowpower_present_line, .awaddr,
		.awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
		.bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
		.irq);
	module_side_model partner (.module_reset_drive_n, .lowpower_line_drive,
		.irq_assert, .present, .at_edge, .shared_irq_reset_line,
		.shared_lowpower_present_line, .in_reset(), .in_lowpower());

	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end

	// ********************************************************
	// Tasks
	// ********************************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic axw(input logic [7:0] a, input logic [31:0] v);
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		// Each channel is released at the edge where its ready is seen
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while ((awvalid && !awready) || (wvalid && !wready));
		do @(posedge aclk); while (!bvalid);
		r = bresp;
		bready <= 1'b0;
	endtask

	task automatic axr(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge aclk); while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	task automatic settle();
		repeat (2) @(posedge aclk);
		#1;
	endtask

	task automatic report_and_stop();
		$display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Hang guard, well above the roughly 1600 cycles used
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			report_and_stop();
		end
	end

	// ********************************************************
	// Main sequence
	// ********************************************************
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata, wstrb} = '0;
		ce = 1'b1;
		{host_reset_request_n, host_lowpower_request_n} = 2'h3;
		{irq_polarity_strap, reset_polarity_strap, present_polarity_strap} = '0;
		lowpower_polarity_strap = 1'b1;
		{irq_assert, present, at_edge} = '0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		settle();
		chk(irq, 1'b0);
		axr(sideband_pkg::THRESH_OFFS);
		chk(d, 32'h9c0);
		axr(8'h40);
		chk(r, sideband_pkg::RESP_DECERR);
		axw(8'h40, 32'h3);
		chk(r, sideband_pkg::RESP_DECERR);
		// Every strap and level combination, half of them on the threshold
		for (int i = 0; i < 256; i++) begin
			@(posedge aclk);
			{irq_polarity_strap, reset_polarity_strap} <= i[1:0];
			{present_polarity_strap, lowpower_polarity_strap} <= i[3:2];
			{irq_assert, present, host_reset_request_n} <= i[6:4];
			host_lowpower_request_n <= i[7];
			at_edge <= i[2];
			settle();
			chk(host_irq_out_n, !irq_assert ^ irq_polarity_strap);
			chk(host_present_out_n, !present ^ present_polarity_strap);
			chk(module_reset_drive_n,
				host_reset_request_n ^ reset_polarity_strap);
			chk(lowpower_line_drive,
				!host_lowpower_request_n ^ lowpower_polarity_strap);
			axr(sideband_pkg::STATUS_OFFS);
			chk(d, {24'h0, lowpower_polarity_strap, present_polarity_strap,
				reset_polarity_strap, irq_polarity_strap,
				!host_lowpower_request_n ^ lowpower_polarity_strap,
				!host_reset_request_n ^ reset_polarity_strap, present,
				irq_assert});
		end
		// Control forces with no host requests pending
		@(posedge aclk);
		{host_reset_request_n, host_lowpower_request_n} <= 2'h3;
		{reset_polarity_strap, lowpower_polarity_strap} <= 2'h0;
		{irq_assert, present} <= 2'h0;
		axw(sideband_pkg::CTRL_OFFS, 32'h3);
		chk(r, sideband_pkg::RESP_OKAY);
		settle();
		chk({module_reset_drive_n, lowpower_line_drive}, 2'h1);
		axr(sideband_pkg::CTRL_OFFS);
		chk(d, 32'h3);
		axw(sideband_pkg::CTRL_OFFS, 32'h0);
		// Interrupt: clear, raise, mask both ways, read-clear
		axr(sideband_pkg::EVENT_OFFS);
		axr(sideband_pkg::EVENT_OFFS);
		chk(d, 32'h0);
		@(posedge aclk);
		irq_assert <= 1'b1;
		settle();
		axw(sideband_pkg::MASK_OFFS, 32'h0);
		settle();
		chk(irq, 1'b0);
		axw(sideband_pkg::MASK_OFFS, 32'h7);
		axr(sideband_pkg::MASK_OFFS);
		chk(d, 32'h7);
		settle();
		chk(irq, 1'b1);
		axr(sideband_pkg::EVENT_OFFS);
		chk(d, 32'h1);
		settle();
		chk(irq, 1'b0);
		// Clock enable low holds the pins while the line moves
		@(posedge aclk);
		ce <= 1'b0;
		irq_assert <= 1'b0;
		settle();
		chk(host_irq_out_n, irq_polarity_strap);
		@(posedge aclk);
		ce <= 1'b1;
		settle();
		chk(host_irq_out_n, !irq_polarity_strap);
		report_and_stop();
	end
endmodule // tb_module_sideband_host_transceiver
